// ===== can_diag_map.svh
// Offsets, field positions, reset values and timing counts of the CAN diag.
`ifndef CAN_DIAG_MAP_SVH
`define CAN_DIAG_MAP_SVH

// Clock rate in MHz; one microsecond is this many cycles.
`define CLK_MHZ          100

// Recessive-dominant cycles that must repeat a fault before it is reported.
`define CONFIRM_CYCLES   3'h5

// Stuck-low and clamp times in microseconds, then derived cycle counts.
`define TXD_STUCK_US     300
`define TXD_STUCK_CYC    (`TXD_STUCK_US * `CLK_MHZ)
`define CLAMP_US         300
`define CLAMP_CYC        (`CLAMP_US * `CLK_MHZ)
`define TMR_W            20

// Bit positions in the synchronised input vector.
`define SB_TXD           8
`define SB_RXD           7
`define SB_DIFF          6
`define SB_GL            5
`define SB_GH            4
`define SB_BL            3
`define SB_BH            2
`define SB_SL            1
`define SB_SH            0
`define SYNC_W           9
// Idle levels: TXD, RXD and receiver recessive, ground comparators high.
`define SYNC_RST         9'h1F0

// Bit positions of the line fault vector.
`define LF_GND_ANY       0
`define LF_BAT_ANY       1
`define LF_CANL_GND      2
`define LF_CANH_GND      3
`define LF_CANL_BAT      4
`define LF_CANH_BAT      5
`define LF_CANL_5V       6
`define LF_CANH_5V       7
`define LF_W             8

`endif

// ===== can_diag_pkg.sv
// Types shared by the CAN fault diagnosis modules.
package can_diag_pkg;

  // Operating mode of the CAN interface.
  typedef enum logic [1:0] {
    MODE_TXRX   = 2'h1,
    MODE_RXONLY = 2'h2
  } mode_e;

  // One bit per decoded line fault.
  typedef logic [7:0] fault_vec_t;

endpackage

// ===== diag_if.sv
// Link between the fault decoder and one fault confirmation counter.
`timescale 1ns/1ns
interface diag_if;
  logic ce;
  logic cycle_done;
  logic hit;
  logic clr;
  logic confirmed;

  modport src (output ce, output cycle_done, output hit, output clr,
               input confirmed);
  modport cnt (input ce, input cycle_done, input hit, input clr,
               output confirmed);
endinterface

// ===== fault_confirm.sv
// Confirms one line fault over consecutive recessive-dominant cycles.
`timescale 1ns/1ns
`include "can_diag_map.svh"
module fault_confirm (
  input wire logic clk,
  input wire logic rst_n,
  diag_if.cnt      dif
);

  logic [2:0] cnt_q;
  logic       conf_q;
  logic       reach;

  // The fifth consecutive hit completes the confirmation.
  assign reach = dif.cycle_done && dif.hit &&
                 (cnt_q == `CONFIRM_CYCLES - 3'h1); // [R5]

  // A cycle without the fault restarts the count; it saturates below five.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else if (dif.ce && dif.cycle_done) begin
      if (!dif.hit) begin
        cnt_q <= 3'h0; // [R5]
      end else if (!reach) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  // Sticky report; a new confirmation beats a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conf_q <= 1'b0;
    end else if (dif.ce) begin
      if (reach) begin
        conf_q <= 1'b1; // [R5]
      end else if (dif.clr) begin
        conf_q <= 1'b0;
      end
    end
  end

  assign dif.confirmed = conf_q;

endmodule

// ===== can_bus_fault_diagnostic.sv
// Bus short, clamp and TXD/RXD pin fault supervision of the CAN transceiver.
// Behaviour
// [R1] Ground comparator pair decodes ground shorts.
// [R2] Battery comparators high in recessive flag battery short.
// [R3] Supply comparator pair decodes 5 V shorts.
// [R4] Recessive detects; dominant samples name the line.
// [R5] Report only after five matching cycles.
// [R6] Long dominant bus sets bus failure flag.
// [R7] Sample RXD at receiver rise; high means fault.
// [R8] RXD fault sets flag, enters receive-only.
// [R9] RXD fault releases RXD driver, reported.
// [R10] Valid TXD low clears RXD fault.
// [R11] RXD flag is its own separate bit.
// [R12] TXD stuck low disables driver, sets flag.
// [R13] Normal command or RXD fall re-enables driver.
// [R14] TXD-RXD short retriggers timeout each lock.
// [R15] Variant C strap omits RXD fault detection.
// [R16] Driver stays off until fault gone, read, commanded.
// [R17] TXD low drives dominant; RXD mirrors bus.
// [R18] Receive-only ignores TXD, still reports bus.
// [R19] Both timeouts are parameterised cycle counts.
`timescale 1ns/1ns
`include "can_diag_map.svh"
module can_bus_fault_diagnostic #(
  parameter int TXD_STUCK_CYCLES = `TXD_STUCK_CYC,
  parameter int CLAMP_CYCLES     = `CLAMP_CYC
) (
  input  wire logic                    CLOCK,
  input  wire logic                    RESETN,
  input  wire logic                    CE,
  input  wire logic                    TXD,
  input  wire logic                    RXD_PIN_IN,
  output logic                         RXD_PIN_OUT,
  output logic                         RXD_PIN_OE_N,
  input  wire logic                    RX_DIFF,
  input  wire logic                    GROUND_CMP_LOW_LINE,
  input  wire logic                    GROUND_CMP_HIGH_LINE,
  input  wire logic                    BATTERY_CMP_LOW_LINE,
  input  wire logic                    BATTERY_CMP_HIGH_LINE,
  input  wire logic                    SUPPLY_CMP_LOW_LINE,
  input  wire logic                    SUPPLY_CMP_HIGH_LINE,
  input  wire logic                    VARIANT_C,
  input  wire logic                    CMD_TXRX,
  input  wire logic                    CMD_RXONLY,
  input  wire logic                    FLAGS_READ,
  output logic                         BUS_DRIVE_EN,
  output logic                         BUS_DOMINANT,
  output logic                         RX_ONLY_MODE,
  output can_diag_pkg::fault_vec_t     LINE_FAULT,
  output logic                         BUS_FAIL_FLAG,
  output logic                         RXD_HIGH_FLAG,
  output logic                         TXD_PERM_FLAG
);

  // Every TXD, RXD, receiver and comparator input passes two flops; only sync_q is read by logic.
  logic [`SYNC_W-1:0] meta_q;
  logic [`SYNC_W-1:0] sync_q;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      meta_q <= `SYNC_RST;
      sync_q <= `SYNC_RST;
    end else if (CE) begin
      meta_q <= {TXD, RXD_PIN_IN, RX_DIFF,
                 GROUND_CMP_LOW_LINE, GROUND_CMP_HIGH_LINE,
                 BATTERY_CMP_LOW_LINE, BATTERY_CMP_HIGH_LINE,
                 SUPPLY_CMP_LOW_LINE, SUPPLY_CMP_HIGH_LINE};
      sync_q <= meta_q;
    end
  end

  logic txd_s;
  logic rxd_s;
  logic diff_s;
  logic diff_d_q;
  logic diff_rise;
  logic diff_fall;

  assign txd_s     = sync_q[`SB_TXD];
  assign rxd_s     = sync_q[`SB_RXD];
  assign diff_s    = sync_q[`SB_DIFF];
  assign diff_rise = diff_s && !diff_d_q;
  assign diff_fall = !diff_s && diff_d_q;

  // Previous receiver level, for edge detection on the synchronised copy.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      diff_d_q <= 1'b1;
    end else if (CE) begin
      diff_d_q <= diff_s;
    end
  end

  // The variant strap is caught once, at the first enabled edge after reset.
  logic strap_done_q;
  logic variant_c_q;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      strap_done_q <= 1'b0;
      variant_c_q  <= 1'b0;
    end else if (CE && !strap_done_q) begin
      strap_done_q <= 1'b1;
      variant_c_q  <= VARIANT_C;
    end
  end

  // Mode, driver and fault state.
  can_diag_pkg::mode_e mode_q;
  logic                drv_en_q;
  logic                drv_dom_q;
  logic                txd_fault_q;
  logic                rxd_fault_q;
  logic                rxd_flag_q;
  logic                txd_flag_q;
  logic                clamp_flag_q;
  logic                rxd_out_q;
  logic                rxd_detect;
  logic                txd_timeout;
  logic                txd_recover;
  logic                clamp_hit;
  logic                drv_en_d;

  // An RXD stuck high shows up at a receiver rise: the pin, which lags
  // the receiver by three cycles, still reads the dominant period. Bits
  // shorter than three cycles are too short to be judged.
  assign rxd_detect = strap_done_q && !variant_c_q && // [R15]
                      !rxd_fault_q && diff_rise && rxd_s; // [R7]

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rxd_fault_q <= 1'b0;
    end else if (CE) begin
      if (rxd_detect) begin
        rxd_fault_q <= 1'b1; // [R7]
      end else if (!txd_s) begin
        rxd_fault_q <= 1'b0; // [R10]
      end
    end
  end

  // Sticky RXD-high flag; detection wins over a read in the same cycle.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rxd_flag_q <= 1'b0;
    end else if (CE) begin
      if (rxd_detect) begin
        rxd_flag_q <= 1'b1; // [R8]
      end else if (FLAGS_READ && !rxd_fault_q) begin
        rxd_flag_q <= 1'b0; // [R16]
      end
    end
  end

  // The RXD pin mirrors the receiver; its driver is released on a fault.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      rxd_out_q    <= 1'b1;
      RXD_PIN_OE_N <= 1'b0;
    end else if (CE) begin
      rxd_out_q    <= diff_s; // [R17]
      RXD_PIN_OE_N <= rxd_fault_q || rxd_detect; // [R9]
    end
  end

  // Mode: receive-only on command or RXD fault; back to TXD/RXD only once
  // the fault is gone and its flag has been read.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      mode_q <= can_diag_pkg::MODE_TXRX;
    end else if (CE) begin
      case (mode_q)
        can_diag_pkg::MODE_TXRX: begin
          if (rxd_detect || CMD_RXONLY) begin
            mode_q <= can_diag_pkg::MODE_RXONLY; // [R8]
          end
        end
        can_diag_pkg::MODE_RXONLY: begin
          if (CMD_TXRX && !rxd_fault_q && !rxd_flag_q) begin
            mode_q <= can_diag_pkg::MODE_TXRX; // [R16]
          end
        end
        default: begin
          mode_q <= can_diag_pkg::MODE_TXRX;
        end
      endcase
    end
  end

  // TXD stuck-low timer. It restarts whenever TXD goes high, so a TXD-RXD
  // short that re-locks the bus is released again after each timeout.
  logic [`TMR_W-1:0] txd_cnt_q;

  assign txd_timeout = !txd_s && !txd_fault_q &&
                       (txd_cnt_q == `TMR_W'(TXD_STUCK_CYCLES - 1)); // [R19]
  assign txd_recover = CMD_TXRX || (txd_s && diff_fall); // [R13]

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      txd_cnt_q <= '0;
    end else if (CE) begin
      if (txd_s || txd_fault_q) begin
        txd_cnt_q <= '0; // [R14]
      end else if (!txd_timeout) begin
        txd_cnt_q <= txd_cnt_q + `TMR_W'(1);
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      txd_fault_q <= 1'b0;
    end else if (CE) begin
      if (txd_timeout) begin
        txd_fault_q <= 1'b1; // [R12]
      end else if (txd_recover) begin
        txd_fault_q <= 1'b0; // [R13]
      end
    end
  end

  // Sticky TXD permanent flag, cleared by a read once the fault has gone.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      txd_flag_q <= 1'b0;
    end else if (CE) begin
      if (txd_timeout) begin
        txd_flag_q <= 1'b1; // [R12]
      end else if (FLAGS_READ && !txd_fault_q) begin
        txd_flag_q <= 1'b0;
      end
    end
  end

  // Driver enable: dropped at once on a fault or receive-only, and raised
  // again only while TXD is recessive so the bus is not grabbed mid-bit.
  always_comb begin
    drv_en_d = drv_en_q;
    if (mode_q != can_diag_pkg::MODE_TXRX || txd_fault_q || txd_timeout) begin
      drv_en_d = 1'b0; // [R18]
    end else if (txd_s) begin
      drv_en_d = 1'b1; // [R13]
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      drv_en_q  <= 1'b0;
      drv_dom_q <= 1'b0;
    end else if (CE) begin
      drv_en_q  <= drv_en_d;
      drv_dom_q <= drv_en_d && !txd_s; // [R17]
    end
  end

  // Bus clamp timer counts receiver dominant time.
  logic [`TMR_W-1:0] clamp_cnt_q;

  assign clamp_hit = !diff_s &&
                     (clamp_cnt_q == `TMR_W'(CLAMP_CYCLES - 1)); // [R19]

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      clamp_cnt_q <= '0;
    end else if (CE) begin
      if (diff_s) begin
        clamp_cnt_q <= '0;
      end else if (!clamp_hit) begin
        clamp_cnt_q <= clamp_cnt_q + `TMR_W'(1);
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      clamp_flag_q <= 1'b0;
    end else if (CE) begin
      if (clamp_hit) begin
        clamp_flag_q <= 1'b1; // [R6]
      end else if (FLAGS_READ) begin
        clamp_flag_q <= 1'b0;
      end
    end
  end

  // Comparators lag the driver by the two sync flops, so the driver state
  // is delayed by the same amount before it splits samples into phases.
  logic       ph_d1_q;
  logic       ph_q;
  logic       ph_prev_q;
  logic       rec_seen_q;
  logic [5:0] rec_q;
  logic [5:0] dom_q;
  logic       cycle_done;

  assign cycle_done = ph_prev_q && !ph_q && rec_seen_q;

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      ph_d1_q    <= 1'b0;
      ph_q       <= 1'b0;
      ph_prev_q  <= 1'b0;
      rec_seen_q <= 1'b0;
      rec_q      <= 6'h30;
      dom_q      <= 6'h10;
    end else if (CE) begin
      ph_d1_q   <= drv_dom_q;
      ph_q      <= ph_d1_q;
      ph_prev_q <= ph_q;
      if (ph_q) begin
        dom_q <= sync_q[5:0]; // [R4]
      end else begin
        rec_q      <= sync_q[5:0];
        rec_seen_q <= 1'b1;
      end
    end
  end

  // Line fault decode from the last recessive and dominant samples.
  logic                     rec_gnd;
  logic                     rec_bat;
  logic                     rec_sup;
  can_diag_pkg::fault_vec_t hit;

  assign rec_gnd = !rec_q[`SB_GL] && !rec_q[`SB_GH]; // [R1]
  assign rec_bat = rec_q[`SB_BL] || rec_q[`SB_BH]; // [R2]
  assign rec_sup = rec_q[`SB_SL] && rec_q[`SB_SH]; // [R3]

  always_comb begin
    hit = '0;
    hit[`LF_GND_ANY]  = rec_gnd; // [R4]
    hit[`LF_BAT_ANY]  = rec_bat; // [R4]
    hit[`LF_CANH_GND] = rec_gnd && !dom_q[`SB_GL] && !dom_q[`SB_GH]; // [R1]
    hit[`LF_CANL_GND] = rec_gnd && !dom_q[`SB_GL] && dom_q[`SB_GH]; // [R1]
    hit[`LF_CANL_BAT] = rec_bat && dom_q[`SB_BL] && dom_q[`SB_BH]; // [R2]
    hit[`LF_CANH_BAT] = rec_bat && !dom_q[`SB_BL] && dom_q[`SB_BH]; // [R2]
    hit[`LF_CANL_5V]  = rec_sup && dom_q[`SB_SL] && dom_q[`SB_SH]; // [R3]
    hit[`LF_CANH_5V]  = rec_sup && !dom_q[`SB_SL] && dom_q[`SB_SH]; // [R3]
  end

  // One confirmation counter per fault kind.
  diag_if dif [`LF_W] ();

  for (genvar i = 0; i < `LF_W; i++) begin : g_conf
    assign dif[i].ce         = CE;
    assign dif[i].cycle_done = cycle_done;
    assign dif[i].hit        = hit[i];
    assign dif[i].clr        = FLAGS_READ;
    assign LINE_FAULT[i]     = dif[i].confirmed;

    fault_confirm u_conf (
      .clk   (CLOCK),
      .rst_n (RESETN),
      .dif   (dif[i])
    );
  end

  // Status outputs; each flag has its own port and is never merged.
  assign RXD_PIN_OUT   = rxd_out_q;
  assign BUS_DRIVE_EN  = drv_en_q;
  assign BUS_DOMINANT  = drv_dom_q;
  assign RX_ONLY_MODE  = (mode_q == can_diag_pkg::MODE_RXONLY);
  assign BUS_FAIL_FLAG = clamp_flag_q;
  assign RXD_HIGH_FLAG = rxd_flag_q; // [R11]
  assign TXD_PERM_FLAG = txd_flag_q;

endmodule

// ===== can_diag_assertions.sv
// Concurrent checks on the ports of the CAN bus fault diagnosis block.
`timescale 1ns/1ns
module can_diag_checker #(
  parameter int TXD_STUCK_CYCLES = 20,
  parameter int CLAMP_CYCLES     = 20
) (
  input wire logic                     CLOCK,
  input wire logic                     RESETN,
  input wire logic                     CE,
  input wire logic                     TXD,
  input wire logic                     RX_DIFF,
  input wire logic                     VARIANT_C,
  input wire logic                     RXD_PIN_OUT,
  input wire logic                     RXD_PIN_OE_N,
  input wire logic                     BUS_DRIVE_EN,
  input wire logic                     BUS_DOMINANT,
  input wire logic                     RX_ONLY_MODE,
  input wire can_diag_pkg::fault_vec_t LINE_FAULT,
  input wire logic                     BUS_FAIL_FLAG,
  input wire logic                     RXD_HIGH_FLAG,
  input wire logic                     TXD_PERM_FLAG
);
  logic [31:0] tlow_q;
  logic [31:0] rdom_q;

  // Raw run lengths; the sync lag is absorbed in the slack of each bound.
  always_ff @(posedge CLOCK) begin
    if (!RESETN || TXD) begin
      tlow_q <= 32'h0;
    end else if (CE) begin
      tlow_q <= tlow_q + 32'h1;
    end
  end

  // Same for a bus held dominant at the receiver.
  always_ff @(posedge CLOCK) begin
    if (!RESETN || RX_DIFF) begin
      rdom_q <= 32'h0;
    end else if (CE) begin
      rdom_q <= rdom_q + 32'h1;
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  tx_follow_a: assert property (
    BUS_DRIVE_EN && $past(BUS_DRIVE_EN) && !RX_ONLY_MODE
    |-> BUS_DOMINANT == !$past(TXD, 3))
    else $error("bus drive does not follow transmit input");
  dom_needs_en_a: assert property (
    BUS_DOMINANT |-> BUS_DRIVE_EN)
    else $error("dominant drive while driver disabled");
  rx_only_off_a: assert property (
    RX_ONLY_MODE && $past(RX_ONLY_MODE) |-> !BUS_DRIVE_EN)
    else $error("driver enabled in receive-only mode");
  rxd_fault_act_a: assert property (
    $rose(RXD_HIGH_FLAG) |-> RXD_PIN_OE_N && RX_ONLY_MODE)
    else $error("stuck-high receive fault not acted on");
  variant_c_a: assert property (
    VARIANT_C |-> !RXD_HIGH_FLAG && !RXD_PIN_OE_N)
    else $error("receive fault detected in variant C");
  txd_perm_off_a: assert property (
    $rose(TXD_PERM_FLAG) |-> !BUS_DRIVE_EN && !BUS_DOMINANT)
    else $error("driver still on after transmit timeout");
  txd_timeout_a: assert property (
    tlow_q >= TXD_STUCK_CYCLES + 5 |-> TXD_PERM_FLAG)
    else $error("transmit stuck low not flagged in time");
  clamp_timeout_a: assert property (
    rdom_q >= CLAMP_CYCLES + 5 |-> BUS_FAIL_FLAG)
    else $error("clamped bus not flagged in time");
  clamp_early_a: assert property (
    $rose(BUS_FAIL_FLAG) |-> $past(rdom_q, 3) >= CLAMP_CYCLES - 2)
    else $error("bus failure flagged too early");
  fault_at_end_a: assert property (
    (LINE_FAULT & ~$past(LINE_FAULT)) != 8'h00
    |-> $past(BUS_DOMINANT, 6) && !$past(BUS_DOMINANT, 2))
    else $error("line fault set away from a cycle end");
  rx_mirror_a: assert property (
    !RXD_PIN_OE_N && $past(RXD_PIN_OE_N, 4) == 1'b0
    |-> RXD_PIN_OUT == $past(RX_DIFF, 3))
    else $error("receive output does not mirror the bus");
endmodule

bind can_bus_fault_diagnostic can_diag_checker #(
  .TXD_STUCK_CYCLES(TXD_STUCK_CYCLES), .CLAMP_CYCLES(CLAMP_CYCLES)
) chk_i (
  .CLOCK(CLOCK), .RESETN(RESETN), .CE(CE), .TXD(TXD), .RX_DIFF(RX_DIFF),
  .VARIANT_C(VARIANT_C), .RXD_PIN_OUT(RXD_PIN_OUT),
  .RXD_PIN_OE_N(RXD_PIN_OE_N), .BUS_DRIVE_EN(BUS_DRIVE_EN),
  .BUS_DOMINANT(BUS_DOMINANT), .RX_ONLY_MODE(RX_ONLY_MODE),
  .LINE_FAULT(LINE_FAULT), .BUS_FAIL_FLAG(BUS_FAIL_FLAG),
  .RXD_HIGH_FLAG(RXD_HIGH_FLAG), .TXD_PERM_FLAG(TXD_PERM_FLAG)
);

// ===== mcu_side.sv
// Controller-side model: drives the transmit pin and resolves the RXD pin.
`timescale 1ns/1ns
module mcu_side (
  input  wire logic tx_bit,
  input  wire logic short_hi,
  input  wire logic rxd_out,
  input  wire logic rxd_oe_n,
  output logic      txd,
  output logic      rxd_in
);
  // The controller's bit stream reaches the transmit pin unchanged.
  assign txd = tx_bit;
  // Weak pull-up on the pin; an external short to the supply beats the driver.
  assign rxd_in = short_hi | rxd_oe_n | rxd_out;
endmodule

// ===== testbench.sv
// Self-checking bench for the CAN bus fault diagnosis block.
`timescale 1ns/1ns
`include "can_diag_map.svh"
module testbench;
  localparam int          TS = 20;
  localparam int          CL = 40;
  localparam logic [35:0] RV = {6'h33, 6'h33, 6'h3C, 6'h3C, 6'h00, 6'h00};
  localparam logic [35:0] DV = {6'h11, 6'h13, 6'h14, 6'h1C, 6'h00, 6'h10};
  logic                     clk, rst_n, tx_bit, stuck, short_hi, var_c;
  logic                     txd, rxd_in, rxd_out, oe_n, rx_diff;
  logic                     cmd_txrx, cmd_rxonly, flags_rd, ce;
  logic [5:0]               comp, rec_v, dom_v;
  logic                     drv_en, bus_dom, rx_only, fail_f, rxd_f, txd_f;
  can_diag_pkg::fault_vec_t line_fault;
  int                       fail_count, cmp_count;

  can_bus_fault_diagnostic #(.TXD_STUCK_CYCLES(TS), .CLAMP_CYCLES(CL)) uut (
    .CLOCK(clk), .RESETN(rst_n), .CE(ce), .TXD(txd),
    .RXD_PIN_IN(rxd_in), .RXD_PIN_OUT(rxd_out), .RXD_PIN_OE_N(oe_n),
    .RX_DIFF(rx_diff), .GROUND_CMP_LOW_LINE(comp[5]),
    .GROUND_CMP_HIGH_LINE(comp[4]), .BATTERY_CMP_LOW_LINE(comp[3]),
    .BATTERY_CMP_HIGH_LINE(comp[2]), .SUPPLY_CMP_LOW_LINE(comp[1]),
    .SUPPLY_CMP_HIGH_LINE(comp[0]), .VARIANT_C(var_c),
    .CMD_TXRX(cmd_txrx), .CMD_RXONLY(cmd_rxonly), .FLAGS_READ(flags_rd),
    .BUS_DRIVE_EN(drv_en), .BUS_DOMINANT(bus_dom), .RX_ONLY_MODE(rx_only),
    .LINE_FAULT(line_fault), .BUS_FAIL_FLAG(fail_f),
    .RXD_HIGH_FLAG(rxd_f), .TXD_PERM_FLAG(txd_f)
  );

  mcu_side ctl (
    .tx_bit(tx_bit), .short_hi(short_hi), .rxd_out(rxd_out),
    .rxd_oe_n(oe_n), .txd(txd), .rxd_in(rxd_in)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The bus and its comparators follow the driver, so they lag it like wires.
  always @(negedge clk) begin
    rx_diff <= !(bus_dom || stuck);
    comp    <= bus_dom ? dom_v : rec_v;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One-cycle command: 0 reads flags, 1 normal mode, 2 receive-only.
  task automatic pulse(input int k);
    flags_rd   = (k == 0);
    cmd_txrx   = (k == 1);
    cmd_rxonly = (k == 2);
    tick(1);
    {flags_rd, cmd_txrx, cmd_rxonly} = 3'h0;
  endtask

  // One dominant bit then one recessive bit, long enough to be judged.
  task automatic bit_cyc();
    tx_bit = 1'b0;
    tick(8);
    tx_bit = 1'b1;
    tick(8);
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #50000;
    fail_count++;
    close_out();
  end

  initial begin
    fail_count = 0;
    cmp_count  = 0;
    ce         = 1'b1;
    {rst_n, stuck, short_hi, var_c, cmd_txrx, cmd_rxonly} = 6'h00;
    {tx_bit, rx_diff, flags_rd} = 3'h6;
    {rec_v, dom_v, comp} = {6'h30, 6'h10, 6'h30};
    tick(5);
    rst_n = 1'b1;
    tick(6);
    chk({drv_en, rx_only}, 2'h2);
    tx_bit = 1'b0;
    tick(4);
    chk(bus_dom, 1'b1);
    tick(4);
    chk(rxd_out, 1'b0);
    tx_bit = 1'b1;
    tick(8);
    pulse(2);
    tick(2);
    chk({rx_only, drv_en}, 2'h2);
    tx_bit = 1'b0;
    tick(5);
    chk(bus_dom, 1'b0);
    tx_bit = 1'b1;
    tick(4);
    pulse(1);
    tick(3);
    chk({rx_only, drv_en}, 2'h1);
    // With the clock enable low a mode command must be lost entirely.
    ce = 1'b0;
    pulse(2);
    tick(2);
    chk({rx_only, drv_en}, 2'h1);
    ce = 1'b1;
    tick(2);
    // Each short is seen four times unreported, then reported on the fifth.
    for (int r = 0; r < 6; r++) begin
      rec_v <= RV[r*6 +: 6];
      dom_v <= DV[r*6 +: 6];
      for (int k = 1; k <= 5; k++) begin
        bit_cyc();
        chk(line_fault[r + `LF_CANL_GND], k == 5);
        // Ground and battery shorts are also flagged without a line name.
        chk(line_fault[1:0], (k < 5) ? 8'h00 : (r < 2) ? 8'h01 :
            (r < 4) ? 8'h02 : 8'h00);
      end
      rec_v <= 6'h30;
      dom_v <= 6'h10;
      bit_cyc();
      pulse(0);
      tick(1);
      chk(line_fault, 8'h00);
    end
    stuck <= 1'b1;
    tick(CL - 2);
    chk(fail_f, 1'b0);
    tick(8);
    chk({fail_f, rxd_f}, 2'h2);
    stuck <= 1'b0;
    tick(6);
    pulse(0);
    tick(1);
    chk(fail_f, 1'b0);
    tx_bit = 1'b0;
    tick(TS + 6);
    chk({txd_f, drv_en, bus_dom}, 3'h4);
    tx_bit = 1'b1;
    tick(3);
    stuck <= 1'b1;
    tick(6);
    stuck <= 1'b0;
    tick(6);
    chk(drv_en, 1'b1);
    pulse(0);
    tick(1);
    chk(txd_f, 1'b0);
    tx_bit = 1'b0;
    tick(TS + 6);
    tx_bit = 1'b1;
    tick(4);
    chk(drv_en, 1'b0);
    pulse(1);
    tick(3);
    chk(drv_en, 1'b1);
    short_hi = 1'b1;
    bit_cyc();
    chk({rxd_f, oe_n, rx_only, drv_en}, 4'hE);
    pulse(1);
    tick(3);
    chk(rx_only, 1'b1);
    short_hi = 1'b0;
    tx_bit = 1'b0;
    tick(6);
    chk({oe_n, bus_dom}, 2'h0);
    tx_bit = 1'b1;
    tick(4);
    pulse(0);
    tick(1);
    pulse(1);
    tick(3);
    chk({rxd_f, rx_only, drv_en}, 3'h1);
    rst_n = 1'b0;
    var_c = 1'b1;
    short_hi = 1'b1;
    tick(5);
    rst_n = 1'b1;
    tick(6);
    bit_cyc();
    chk({rxd_f, oe_n}, 2'h0);
    close_out();
  end
endmodule
